// file: rtl/load_store_unit.sv
`timescale 1ns/1ps
`default_nettype none
module load_store_unit #(
  parameter int RF_DEPTH = 16
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        ENDIAN_SELECT_I,
  output logic      [31:0] MEM_ADDR_O,
  output logic      [31:0] MEM_WDATA_O,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic             MEM_BYTE_O,
  output logic             MEM_USER_O,
  input  wire logic [31:0] MEM_RDATA_I,
  input  wire logic        MEM_ACK_I,
  input  wire logic        MEM_ABORT_I,
  output logic             BUSY_O,
  output logic             ABORT_TRAP_O
);
  import ls_pkg::*;

  ls_state_t   state_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] instr_ff;
  logic [31:0] pc_ff;
  logic        done_ff;
  logic [3:0]  cycles_ff;
  logic [31:0] base_ff;
  logic [31:0] ofs_ff;
  logic [31:0] new_base_ff;
  logic [31:0] load_ff;
  logic        pend_ff;
  logic [31:0] rf_q;
  logic [3:0]  rf_raddr;
  logic        rf_we;
  logic [31:0] rf_wdata;
  logic [3:0]  rf_waddr;
  logic        fsm_we;
  logic [3:0]  fsm_waddr;
  logic [31:0] fsm_wdata;
  logic        endian_s1_ff;
  logic        endian_ff;
  logic [31:0] rdata_s1_ff;
  logic [31:0] rdata_ff;
  logic        ack_s1_ff;
  logic        ack_ff;
  logic        abort_s1_ff;
  logic        abort_ff;

  // Instruction fields.
  logic        f_imm;
  logic        f_pre;
  logic        f_up;
  logic        f_byte;
  logic        f_wb;
  logic        f_load;
  logic [3:0]  f_base;
  logic [3:0]  f_rd;
  logic [3:0]  f_idx;
  logic [4:0]  f_amt;
  logic [1:0]  f_type;

  assign f_imm  = instr_ff[INS_IMM_BIT];
  assign f_pre  = instr_ff[INS_PRE_BIT];
  assign f_up   = instr_ff[INS_UP_BIT];
  assign f_byte = instr_ff[INS_BYTE_BIT];
  assign f_wb   = instr_ff[INS_WB_BIT];
  assign f_load = instr_ff[INS_LOAD_BIT];
  assign f_base = instr_ff[INS_BASE_LSB +: 4];
  assign f_rd   = instr_ff[INS_RD_LSB +: 4];
  assign f_idx  = instr_ff[3:0];
  assign f_amt  = instr_ff[INS_AMT_LSB +: 5];
  assign f_type = instr_ff[INS_TYPE_LSB +: 2];

  // Register offset shifter; amount zero encodes 32 (LSR, ASR) or extended rotate (ROR).
  function automatic logic [31:0] shift_ofs(input logic [31:0] v,
                                            input logic [1:0]  ty,
                                            input logic [4:0]  amt,
                                            input logic        cin);
    logic [31:0] r;
    r = v;
    case (ty)
      SH_LSL: r = v << amt;
      SH_LSR: r = (amt == 5'h00) ? 32'h0000_0000 : (v >> amt);
      SH_ASR: r = (amt == 5'h00) ? {32{v[31]}}
                                 : 32'($signed(v) >>> amt);
      SH_ROR: r = (amt == 5'h00) ? {cin, v[31:1]}
                                 : ((v >> amt) | (v << (6'h20 - {1'b0, amt})));
      default: r = v;
    endcase
    return r;
  endfunction

  // Bus-facing bookkeeping.
  logic        wb_req;
  logic        wb_wr;
  logic        wb_en;
  logic        idle;
  logic [31:0] wmask;
  logic        rf_hit;
  logic        start;

  assign idle   = (state_ff == S_IDLE);
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~pend_ff;
  // Writes land on the edge where the master samples ack.
  assign wb_wr  = WB_ACK_O & WB_CYC_I & WB_STB_I & WB_WE_I;
  assign wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                   {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign rf_hit = (WB_ADR_I >= RF_BASE_OFS) && (WB_ADR_I <= RF_LAST_OFS);
  assign start  = wb_wr && (WB_ADR_I == CTRL_OFS) && idle
                  && WB_SEL_I[0] && WB_DAT_I[CTRL_START_BIT];

  // Outside levels pass two flops before anything looks at them.
  always_ff @(posedge CLK_SYS_I) begin
    endian_s1_ff <= ENDIAN_SELECT_I;
    endian_ff    <= endian_s1_ff;
    rdata_s1_ff  <= MEM_RDATA_I;
    rdata_ff     <= rdata_s1_ff;
    ack_s1_ff    <= MEM_ACK_I;
    ack_ff       <= ack_s1_ff;
    abort_s1_ff  <= MEM_ABORT_I;
    abort_ff     <= abort_s1_ff;
  end

  // Wishbone slave: ack two cycles after the request, one cycle wide.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      pend_ff  <= 1'b0;
      WB_ACK_O <= 1'b0;
    end else begin
      pend_ff  <= wb_req;
      WB_ACK_O <= pend_ff;
    end
  end

  // Read data mux; register file entries other than the PC are hidden while an access runs.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (pend_ff) begin
      if (rf_hit) begin
        if (WB_ADR_I[5:2] == PC_INDEX) begin
          WB_DAT_O <= pc_ff & PC_LOW_MASK;
        end else begin
          WB_DAT_O <= idle ? rf_q : 32'h0000_0000;
        end
      end else begin
        case (WB_ADR_I)
          CTRL_OFS:      WB_DAT_O <= ctrl_ff;
          INSTR_OFS:     WB_DAT_O <= instr_ff;
          INSTR_ADR_OFS: WB_DAT_O <= pc_ff & PC_LOW_MASK;
          STATUS_OFS: begin
            WB_DAT_O <= 32'h0000_0000;
            WB_DAT_O[STAT_BUSY_BIT]   <= ~idle;
            WB_DAT_O[STAT_DONE_BIT]   <= done_ff;
            WB_DAT_O[STAT_ABORT_BIT]  <= ABORT_TRAP_O;
            WB_DAT_O[STAT_ENDIAN_BIT] <= endian_ff;
            WB_DAT_O[STAT_CYC_LSB +: 4] <= cycles_ff;
          end
          default:       WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; the start bit never stores, it only triggers.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      ctrl_ff <= CTRL_RST;
    end else if (wb_wr && WB_ADR_I == CTRL_OFS) begin
      ctrl_ff <= ((ctrl_ff & ~wmask) | (WB_DAT_I & wmask))
                 & ~(32'h1 << CTRL_START_BIT);
    end
  end

  // The instruction word is frozen while it executes.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      instr_ff <= INSTR_RST;
    end else if (wb_wr && idle && WB_ADR_I == INSTR_OFS) begin
      instr_ff <= (instr_ff & ~wmask) | (WB_DAT_I & wmask);
    end
  end

  // Program counter; the low two bits are dropped on every write.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      pc_ff <= PC_RST;
    end else if (fsm_we && fsm_waddr == PC_INDEX) begin
      pc_ff <= fsm_wdata & PC_LOW_MASK;
    end else if (wb_wr && idle && (WB_ADR_I == INSTR_ADR_OFS ||
                 (rf_hit && WB_ADR_I[5:2] == PC_INDEX))) begin
      pc_ff <= ((pc_ff & ~wmask) | (WB_DAT_I & wmask)) & PC_LOW_MASK;
    end
  end

  // Core cycle count, fixed when the instruction starts.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      cycles_ff <= 4'h0;
    end else if (start) begin
      if (f_load) begin
        cycles_ff <= CYC_BASE
          + ((f_imm && !(f_type == SH_LSL && f_amt <= LSL_FREE_MAX))
             ? CYC_SHIFT : 4'h0)
          + ((f_rd == PC_INDEX) ? CYC_PC_LOAD : 4'h0);
      end else begin
        cycles_ff <= CYC_BASE + (f_imm ? CYC_SHIFT : 4'h0);
      end
    end
  end

  // Done and abort flags are sticky; a new event beats a clear.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      done_ff      <= 1'b0;
      ABORT_TRAP_O <= 1'b0;
    end else begin
      if (state_ff == S_MEM && abort_ff) begin
        ABORT_TRAP_O <= 1'b1;
      end else if (wb_wr && WB_ADR_I == STATUS_OFS && WB_SEL_I[0]
                   && WB_DAT_I[STAT_ABORT_BIT]) begin
        ABORT_TRAP_O <= 1'b0;
      end
      if ((state_ff == S_MEM && ack_ff && !abort_ff && !f_load && !wb_en)
          || state_ff == S_WR_BASE
          || (state_ff == S_WR_DEST && !wb_en)) begin
        done_ff <= 1'b1;
      end else if (wb_wr && WB_ADR_I == STATUS_OFS && WB_SEL_I[0]
                   && WB_DAT_I[STAT_DONE_BIT]) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Address generation and lane steering.
  logic [31:0] ea;
  logic [31:0] xfer_addr;
  logic [4:0]  rot;
  logic [1:0]  lane;
  logic [31:0] rotated;
  logic [31:0] load_val;

  assign ea        = f_up ? base_ff + ofs_ff : base_ff - ofs_ff;
  assign xfer_addr = f_pre ? ea : base_ff;
  assign wb_en     = f_wb | ~f_pre;
  // Both endians rotate by eight per offset; big-endian lanes just count
  // from the top, which gives the same rotation for word loads.
  assign rot       = {MEM_ADDR_O[1:0], 3'h0};
  assign rotated   = (rdata_ff >> rot)
                     | (rdata_ff << (6'h20 - {1'b0, rot}));
  assign lane      = endian_ff ? ~MEM_ADDR_O[1:0]
                               : MEM_ADDR_O[1:0];
  assign load_val  = MEM_BYTE_O
                     ? {24'h00_0000, 8'(rdata_ff >> {lane, 3'h0})}
                     : rotated;

  // Register file port use by the sequencer.
  always_comb begin
    fsm_we    = 1'b0;
    fsm_waddr = f_rd;
    fsm_wdata = load_ff;
    case (state_ff)
      S_WR_DEST: fsm_we = 1'b1;
      S_WR_BASE: begin
        fsm_we    = 1'b1;
        fsm_waddr = f_base;
        fsm_wdata = new_base_ff;
      end
      default:   fsm_we = 1'b0;
    endcase
  end

  always_comb begin
    case (state_ff)
      S_RD_BASE: rf_raddr = f_base;
      S_RD_OFS:  rf_raddr = f_idx;
      S_RD_DATA: rf_raddr = f_rd;
      default:   rf_raddr = WB_ADR_I[5:2];
    endcase
  end

  assign rf_we    = (fsm_we && fsm_waddr != PC_INDEX)
                    || (wb_wr && idle && rf_hit && WB_ADR_I[5:2] != PC_INDEX);
  assign rf_waddr = fsm_we ? fsm_waddr : WB_ADR_I[5:2];
  assign rf_wdata = fsm_we ? fsm_wdata
                    : (rf_q & ~wmask) | (WB_DAT_I & wmask);

  rf_mem #(
    .WIDTH (32),
    .DEPTH (RF_DEPTH),
    .AW    (4)
  ) u_rf (
    .CLK_SYS_I (CLK_SYS_I),
    .we_i      (rf_we),
    .waddr_i   (rf_waddr),
    .wdata_i   (rf_wdata),
    .raddr_i   (rf_raddr),
    .rdata_o   (rf_q)
  );

  // Sequencer: gather operands, run the access, then write back.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE:    if (start) state_ff <= S_RD_BASE;
        S_RD_BASE: state_ff <= S_RD_OFS;
        S_RD_OFS:  state_ff <= S_RD_DATA;
        S_RD_DATA: state_ff <= S_CALC;
        // Wait for the previous handshake to clear before a new request.
        S_CALC:    if (!ack_ff && !abort_ff) state_ff <= S_MEM;
        S_MEM: begin
          if (abort_ff) begin
            state_ff <= S_IDLE;
          end else if (ack_ff) begin
            if (f_load) begin
              state_ff <= S_WR_DEST;
            end else begin
              state_ff <= wb_en ? S_WR_BASE : S_IDLE;
            end
          end
        end
        S_WR_DEST: state_ff <= wb_en ? S_WR_BASE : S_IDLE;
        S_WR_BASE: state_ff <= S_IDLE;
        default:   state_ff <= S_IDLE;
      endcase
    end
  end

  // Operand capture; the PC reads eight ahead of the instruction.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      base_ff     <= 32'h0000_0000;
      ofs_ff      <= 32'h0000_0000;
      new_base_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        S_RD_OFS:  base_ff <= (f_base == PC_INDEX)
                              ? (pc_ff & PC_LOW_MASK) + PC_AHEAD
                              : rf_q;
        S_RD_DATA: ofs_ff <= f_imm
                             ? shift_ofs(rf_q, f_type, f_amt,
                                         ctrl_ff[CTRL_CARRY_BIT])
                             : {20'h0_0000, instr_ff[11:0]};
        S_CALC:    new_base_ff <= ea;
        default: base_ff <= base_ff;
      endcase
    end
  end

  // Memory request; held until the synchronised ack or abort returns.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      MEM_REQ_O   <= 1'b0;
      MEM_ADDR_O  <= 32'h0000_0000;
      MEM_WDATA_O <= 32'h0000_0000;
      MEM_WE_O    <= 1'b0;
      MEM_BYTE_O  <= 1'b0;
      MEM_USER_O  <= 1'b0;
    end else if (state_ff == S_CALC && !ack_ff && !abort_ff) begin
      MEM_REQ_O   <= 1'b1;
      MEM_ADDR_O  <= xfer_addr;
      MEM_WE_O    <= ~f_load;
      MEM_BYTE_O  <= f_byte;
      MEM_USER_O  <= ~f_pre & f_wb & ctrl_ff[CTRL_PRIV_BIT];
      MEM_WDATA_O <= f_byte
                     ? {4{rf_q[7:0]}}
                     : ((f_rd == PC_INDEX) ? (pc_ff & PC_LOW_MASK) + PC_AHEAD
                                           : rf_q);
    end else if (state_ff == S_MEM && (ack_ff || abort_ff)) begin
      MEM_REQ_O <= 1'b0;
    end
  end

  // Load result and busy level.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      load_ff <= 32'h0000_0000;
      BUSY_O  <= 1'b0;
    end else begin
      if (state_ff == S_MEM && ack_ff && !abort_ff) begin
        load_ff <= load_val;
      end
      BUSY_O <= start || (!idle && !(state_ff == S_WR_BASE)
                && !(state_ff == S_MEM && abort_ff)
                && !(state_ff == S_MEM && ack_ff && !f_load && !wb_en)
                && !(state_ff == S_WR_DEST && !wb_en));
    end
  end

endmodule
`default_nettype wire

// file: rtl/ls_pkg.sv
package ls_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] INSTR_OFS     = 8'h04;
  localparam logic [7:0] INSTR_ADR_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0c;
  localparam logic [7:0] RF_BASE_OFS   = 8'h40;
  localparam logic [7:0] RF_LAST_OFS   = 8'h7c;

  // Control register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_PRIV_BIT  = 1;
  localparam int CTRL_CARRY_BIT = 2;

  // Status register fields.
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_ABORT_BIT  = 2;
  localparam int STAT_ENDIAN_BIT = 3;
  localparam int STAT_CYC_LSB    = 8;

  // Instruction word fields.
  localparam int INS_IMM_BIT  = 25;
  localparam int INS_PRE_BIT  = 24;
  localparam int INS_UP_BIT   = 23;
  localparam int INS_BYTE_BIT = 22;
  localparam int INS_WB_BIT   = 21;
  localparam int INS_LOAD_BIT = 20;
  localparam int INS_BASE_LSB = 16;
  localparam int INS_RD_LSB   = 12;
  localparam int INS_AMT_LSB  = 7;
  localparam int INS_TYPE_LSB = 5;

  // Shift types of a register offset.
  localparam logic [1:0] SH_LSL = 2'h0;
  localparam logic [1:0] SH_LSR = 2'h1;
  localparam logic [1:0] SH_ASR = 2'h2;
  localparam logic [1:0] SH_ROR = 2'h3;

  // Reset values and fixed figures.
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] INSTR_RST    = 32'h0000_0000;
  localparam logic [31:0] PC_RST       = 32'h0000_0000;
  localparam logic [31:0] PC_AHEAD     = 32'h0000_0008;
  localparam logic [31:0] PC_LOW_MASK  = 32'hffff_fffc;
  localparam logic [3:0]  PC_INDEX     = 4'hf;
  localparam logic [4:0]  LSL_FREE_MAX = 5'h03;

  // Core cycle figures.
  localparam logic [3:0] CYC_BASE    = 4'h1;
  localparam logic [3:0] CYC_SHIFT   = 4'h1;
  localparam logic [3:0] CYC_PC_LOAD = 4'h4;

  typedef enum logic [3:0] {
    S_IDLE,
    S_RD_BASE,
    S_RD_OFS,
    S_RD_DATA,
    S_CALC,
    S_MEM,
    S_WR_DEST,
    S_WR_BASE
  } ls_state_t;

endpackage

// file: rtl/rf_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rf_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Contents need no reset; software loads them before use.
  always_ff @(posedge CLK_SYS_I) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // Read data leave through a register, one cycle after the address.
  always_ff @(posedge CLK_SYS_I) begin
    rdata_o <= mem_ff[raddr_i];
  end

endmodule
`default_nettype wire

// file: verification/lsu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsu_mem_model (
  input  wire logic        clk_i,
  input  wire logic        endian_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        byte_i,
  input  wire logic        user_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        abort_en_i,
  input  wire logic [3:0]  dly_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o,
  output logic             abort_o
);
  logic [31:0] mem [64];
  logic [31:0] last_adr;
  logic        last_user;
  logic [3:0]  wait_cnt;
  logic [1:0]  lane;
  logic [5:0]  idx;

  // Every byte starts out holding its own little-endian byte address.
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
    end
    rdata_o = 32'h0;
    ack_o = 1'b0;
    abort_o = 1'b0;
    wait_cnt = 4'h0;
  end

  // Big-endian numbering counts lanes down from the top of the word.
  assign idx  = addr_i[7:2];
  assign lane = endian_i ? 2'h3 - addr_i[1:0] : addr_i[1:0];

  // Answers after dly_i cycles, holding ack or abort until req falls.
  // Read data toggles whenever it is not valid, so stale data never matches.
  always @(posedge clk_i) begin
    if (!req_i || (!ack_o && !abort_o && wait_cnt != dly_i)) begin
      ack_o <= req_i & ack_o;
      abort_o <= req_i & abort_o;
      wait_cnt <= req_i ? wait_cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end else if (!ack_o && !abort_o) begin
      last_adr <= addr_i;
      last_user <= user_i;
      if (abort_en_i) begin
        abort_o <= 1'b1;
      end else begin
        ack_o <= 1'b1;
        if (!we_i) begin
          rdata_o <= mem[idx];
        end else if (byte_i) begin
          mem[idx][8*lane +: 8] <= wdata_i[8*lane +: 8];
        end else begin
          mem[idx] <= wdata_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/load_store_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module load_store_unit_properties
  import ls_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RST_B_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic [31:0] MEM_WDATA_O,
  input wire logic        MEM_REQ_O,
  input wire logic        MEM_WE_O,
  input wire logic        MEM_BYTE_O,
  input wire logic        MEM_ACK_I,
  input wire logic        MEM_ABORT_I,
  input wire logic        BUSY_O,
  input wire logic        ABORT_TRAP_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  logic wr_ok;
  logic start_wr;
  logic trap_clr;

  // Writes land only on the edge where the slave acknowledges.
  assign wr_ok    = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  assign start_wr = wr_ok && WB_ADR_I == CTRL_OFS && WB_DAT_I[0] && !BUSY_O;
  assign trap_clr = wr_ok && WB_ADR_I == STATUS_OFS && WB_DAT_I[2];

  sequence s_launch;
    ##[1:2] BUSY_O ##[1:8] MEM_REQ_O;
  endsequence
  sequence s_mem_answer;
    $rose(MEM_ACK_I || MEM_ABORT_I);
  endsequence

  a_wb_ack_latency: assert property ($rose(WB_CYC_I && WB_STB_I) |->
    !WB_ACK_O ##[1:3] WB_ACK_O) else $error("bus ack late or early");
  a_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");
  a_byte_replicate: assert property (MEM_REQ_O && MEM_WE_O && MEM_BYTE_O
    |-> MEM_WDATA_O == {4{MEM_WDATA_O[7:0]}}) else $error("byte not copied");
  a_req_steady: assert property (MEM_REQ_O && !MEM_ACK_I && !MEM_ABORT_I
    |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WDATA_O))
    else $error("memory request changed before answer");
  a_req_release: assert property (s_mem_answer |->
    MEM_REQ_O ##[1:4] !MEM_REQ_O) else $error("request not released");
  a_abort_trap: assert property ($rose(MEM_ABORT_I) |->
    ##[1:6] ABORT_TRAP_O) else $error("abort trap not taken");
  a_trap_sticky: assert property (ABORT_TRAP_O && !trap_clr |=>
    ABORT_TRAP_O) else $error("abort trap cleared by itself");
  a_reset_quiet: assert property ($rose(RST_B_I) |-> !MEM_REQ_O && !BUSY_O
    && !ABORT_TRAP_O && !WB_ACK_O) else $error("outputs active after reset");
  a_start_req: assert property (start_wr |-> s_launch)
    else $error("start did not reach memory");
  a_idle_no_req: assert property (!BUSY_O |-> !MEM_REQ_O)
    else $error("memory request while idle");
endmodule

bind load_store_unit load_store_unit_properties chk (.*);
`default_nettype wire

// file: verification/load_store_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module load_store_unit_tb_top;
  import ls_pkg::*;
  logic CLK_SYS_I, RST_B_I, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O;
  logic ENDIAN_SELECT_I, MEM_REQ_O, MEM_WE_O, MEM_BYTE_O, MEM_USER_O;
  logic MEM_ACK_I, MEM_ABORT_I, BUSY_O, ABORT_TRAP_O, abort_en;
  logic [7:0]  WB_ADR_I, a;
  logic [3:0]  WB_SEL_I, dly;
  logic [31:0] WB_DAT_I, WB_DAT_O, MEM_ADDR_O, MEM_WDATA_O, MEM_RDATA_I;
  logic [31:0] q, exp;
  int          errors;
  int          checks_done;
  localparam logic [5:0] LDB = 6'h1d, LDW = 6'h19, STB = 6'h1c, STW = 6'h18;
  localparam logic [5:0] LWR = 6'h39, SWR = 6'h38;

  load_store_unit dut (.*);
  lsu_mem_model mem (.clk_i(CLK_SYS_I), .endian_i(ENDIAN_SELECT_I),
    .req_i(MEM_REQ_O), .we_i(MEM_WE_O), .byte_i(MEM_BYTE_O),
    .user_i(MEM_USER_O), .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O),
    .abort_en_i(abort_en), .dly_i(dly), .rdata_o(MEM_RDATA_I),
    .ack_o(MEM_ACK_I), .abort_o(MEM_ABORT_I));

  // Free-running 100 MHz system clock.
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One classic cycle; entered just after an edge, read data lands in q.
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= ad;
    WB_DAT_I <= d;
    do begin
      @(posedge CLK_SYS_I);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 40);
    if (n == 40) errors++;
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask

  task automatic rf_wr(input logic [3:0] n, input logic [31:0] v);
    wb(1'b1, RF_BASE_OFS + {2'h0, n, 2'h0}, v);
  endtask
  task automatic rf_rd(input logic [3:0] n);
    wb(1'b0, RF_BASE_OFS + {2'h0, n, 2'h0}, 32'h0);
  endtask

  // Runs one privileged instruction and checks its reported core cycles.
  task automatic run(input logic [31:0] ins, input logic [3:0] cyc);
    int n;
    n = 0;
    wb(1'b1, INSTR_OFS, ins);
    wb(1'b1, CTRL_OFS, 32'h3);
    do begin
      wb(1'b0, STATUS_OFS, 32'h0);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 30);
    if (q[STAT_BUSY_BIT] !== 1'b0) errors++;
    check(32'(q[11:8]), 32'(cyc));
  endtask

  function automatic logic [31:0] ins(input logic [5:0] f,
      input logic [3:0] bn, input logic [3:0] rd, input logic [11:0] off);
    return {6'h39, f, bn, rd, off};
  endfunction
  function automatic logic [31:0] ror(input logic [31:0] x, input int k);
    return (x >> (8 * k)) | (x << (32 - 8 * k));
  endfunction

  // Hang guard: the whole sequence needs well under a tenth of this.
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    {RST_B_I, WB_WE_I, WB_CYC_I, WB_STB_I, ENDIAN_SELECT_I, abort_en} = '0;
    {WB_ADR_I, WB_DAT_I, dly} = '0;
    WB_SEL_I = 4'hf;
    repeat (2) @(posedge CLK_SYS_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_SYS_I);
    wb(1'b0, 8'h30, 32'h0);
    check(q, 32'h0);
    rf_wr(4'h0, 32'h0);
    rf_wr(4'ha, 32'h1122_3344);
    WB_SEL_I <= 4'h2;
    rf_wr(4'ha, 32'haabb_ccdd);
    WB_SEL_I <= 4'hf;
    rf_rd(4'ha);
    check(q, 32'h1122_cc44);
    for (int e = 0; e < 2; e++) begin
      ENDIAN_SELECT_I <= e[0];
      repeat (3) @(posedge CLK_SYS_I);
      for (int k = 0; k < 4; k++) begin
        rf_wr(4'h2, 32'hffff_ffff);
        run(ins(LDB, 4'h0, 4'h2, 12'h10 + 12'(k)), 4'h1);
        rf_rd(4'h2);
        check(q, 32'(e ? 19 - k : 16 + k));
        run(ins(LDW, 4'h0, 4'h3, 12'h10 + 12'(k)), 4'h1);
        rf_rd(4'h3);
        check(q, ror(32'h1312_1110, k));
        a = 8'h20 + 8'(16 * e + 4 * k);
        rf_wr(4'h4, 32'hdead_bea5);
        run(ins(STB, 4'h0, 4'h4, {4'h0, a + 8'(k)}), 4'h1);
        run(ins(LDW, 4'h0, 4'h5, {4'h0, a}), 4'h1);
        rf_rd(4'h5);
        exp = {a + 8'h3, a + 8'h2, a + 8'h1, a};
        exp[8 * (e ? 3 - k : k) +: 8] = 8'ha5;
        check(q, exp);
      end
      wb(1'b0, STATUS_OFS, 32'h0);
      check(32'(q[STAT_ENDIAN_BIT]), 32'(e));
    end
    rf_wr(4'h4, 32'h8765_4321);
    run(ins(STW, 4'h0, 4'h4, 12'h42), 4'h1);
    run(ins(LDW, 4'h0, 4'h5, 12'h40), 4'h1);
    rf_rd(4'h5);
    check(q, 32'h8765_4321);
    // Program counter ops stay word form, no write-back.
    wb(1'b1, INSTR_ADR_OFS, 32'h53);
    run(ins(LDW, 4'hf, 4'h3, 12'h10), 4'h1);
    check(mem.last_adr, 32'h68);
    rf_rd(4'hf);
    check(32'(q[1:0]), 32'h0);
    wb(1'b1, INSTR_ADR_OFS, 32'h53);
    run(ins(STW, 4'h0, 4'hf, 12'h44), 4'h1);
    run(ins(LDW, 4'h0, 4'h5, 12'h44), 4'h1);
    rf_rd(4'h5);
    check(q, 32'h58);
    rf_wr(4'h6, 32'h4);
    run(ins(LWR, 4'h0, 4'h3, {5'h3, SH_LSL, 1'b0, 4'h6}), 4'h1);
    run(ins(LWR, 4'h0, 4'h3, {5'h4, SH_LSL, 1'b0, 4'h6}), 4'h2);
    run(ins(LWR, 4'h0, 4'h3, {5'h1, SH_LSR, 1'b0, 4'h6}), 4'h2);
    run(ins(LWR, 4'h0, 4'h3, {5'h1, SH_ASR, 1'b0, 4'h6}), 4'h2);
    run(ins(LWR, 4'h0, 4'h3, {5'h1, SH_ROR, 1'b0, 4'h6}), 4'h2);
    check(mem.last_adr, 32'h2);
    run(ins(SWR, 4'h0, 4'h3, {5'h0, SH_LSL, 1'b0, 4'h6}), 4'h2);
    run(ins(LDW, 4'h0, 4'hf, 12'h48), 4'h5);
    // Slow memory from here on; base and destination differ.
    rf_wr(4'h7, 32'h30);
    rf_wr(4'h8, 32'h1234);
    abort_en <= 1'b1;
    dly <= 4'h5;
    run(ins(6'h03, 4'h7, 4'h8, 12'h4), 4'h1);
    check(32'(ABORT_TRAP_O), 32'h1);
    rf_rd(4'h7);
    check(q, 32'h30);
    rf_rd(4'h8);
    check(q, 32'h1234);
    wb(1'b1, STATUS_OFS, 32'h6);
    check(32'(ABORT_TRAP_O), 32'h0);
    abort_en <= 1'b0;
    run(ins(6'h03, 4'h7, 4'h9, 12'h4), 4'h1);
    check(mem.last_adr, 32'h30);
    check(32'(mem.last_user), 32'h1);
    rf_rd(4'h7);
    check(q, 32'h2c);
    run(ins(6'h13, 4'h7, 4'h9, 12'h4), 4'h1);
    check(mem.last_adr, 32'h28);
    check(32'(mem.last_user), 32'h0);
    rf_rd(4'h7);
    check(q, 32'h28);
    tally_and_finish();
  end
endmodule
`default_nettype wire
